// [common/acp_pkg.sv]
package acp_pkg;
  localparam int ACP_DATA_W = 8;
  localparam int ACP_CH_NUM = 24;
  // register byte addresses
  localparam logic [11:0] ACP_OFS_CFG = 12'h000;
  localparam logic [11:0] ACP_OFS_PIN_LO = 12'h004;
  localparam logic [11:0] ACP_OFS_PIN_MID = 12'h008;
  localparam logic [11:0] ACP_OFS_PIN_HI = 12'h00C;
  // configuration field positions
  localparam int ACP_CFG_LPC_BIT = 7;
  localparam int ACP_CFG_DIV_LSB = 5;
  localparam int ACP_CFG_LSMP_BIT = 4;
  localparam int ACP_CFG_MODE_LSB = 2;
  localparam int ACP_CFG_CLK_LSB = 0;
  // reset values
  localparam logic [7:0] ACP_RST_CFG = 8'h00;
  localparam logic [7:0] ACP_RST_PIN = 8'h00;
  localparam logic [23:0] ACP_RST_PIN_ALL = 24'h00_0000;
  typedef enum logic [1:0] {
    ACP_DIV_1 = 2'b00,
    ACP_DIV_2 = 2'b01,
    ACP_DIV_4 = 2'b10,
    ACP_DIV_8 = 2'b11
  } acp_div_t;
  typedef enum logic [1:0] {
    ACP_MODE_8B = 2'b00,
    ACP_MODE_RSV1 = 2'b01,
    ACP_MODE_10B = 2'b10,
    ACP_MODE_RSV3 = 2'b11
  } acp_mode_t;
  typedef enum logic [1:0] {
    ACP_SRC_BUS = 2'b00,
    ACP_SRC_BUS_HALF = 2'b01,
    ACP_SRC_ALT = 2'b10,
    ACP_SRC_ASYNC = 2'b11
  } acp_src_t;
endpackage

// [logic/acp_clk_div.sv]
module acp_clk_div
  import acp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic src_tick,
  input wire logic [1:0] div_sel,
  input wire logic restart,
  output logic tick_ff
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic [2:0] limit;

  always_comb begin
    unique case (acp_div_t'(div_sel))
      ACP_DIV_1: limit = 3'd0;
      ACP_DIV_2: limit = 3'd1;
      ACP_DIV_4: limit = 3'd3;
      ACP_DIV_8: limit = 3'd7;
    endcase
    nxt_cnt = (cnt_ff >= limit) ? 3'd0 : cnt_ff + 3'd1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 3'd0;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      if (restart) begin
        cnt_ff <= 3'd0;
        tick_ff <= 1'b0;
      end else if (src_tick) begin
        cnt_ff <= nxt_cnt;
        tick_ff <= (cnt_ff >= limit);
      end else begin
        tick_ff <= 1'b0;
      end
    end
  end
endmodule // acp_clk_div

// [logic/acp_top.sv]
module acp_top
  import acp_pkg::*;
#(
  parameter logic [23:0] CH_PRESENT = 24'hFF_FFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alternate_clock_source,
  input wire logic internal_async_clock,
  output logic low_power_select,
  output logic long_sample_select,
  output logic [1:0] mode_select,
  output logic mode_10bit,
  output logic mode_reserved,
  output logic converter_clock,
  output logic conversion_abort,
  output logic [23:0] pin_out_tristate,
  output logic [23:0] pin_pullup_off,
  output logic [23:0] pin_input_off
);
  localparam bit HAS_MID = |CH_PRESENT[15:8];
  localparam bit HAS_HI = |CH_PRESENT[23:16];

  // elaboration check: at least one channel must exist
  if (CH_PRESENT == 24'h00_0000) begin : g_no_channel
    $error("acp_top: no analog channel present");
  end

  logic [7:0] cfg_ff;
  logic [23:0] pin_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic abort_ff;
  logic [1:0] alt_sync_ff;
  logic [1:0] async_sync_ff;
  logic alt_prev_ff;
  logic async_prev_ff;
  logic half_ff;
  logic [23:0] dis_ff;
  logic lpc_ff;
  logic lsmp_ff;
  logic [1:0] mode_ff;
  logic m10_ff;
  logic mrsv_ff;

  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic cfg_wr;
  logic src_tick;
  logic div_tick;

  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == ACP_OFS_CFG) || (a == ACP_OFS_PIN_LO)
           || (HAS_MID && a == ACP_OFS_PIN_MID)
           || (HAS_HI && a == ACP_OFS_PIN_HI);
  endfunction

  assign hit = reg_hit(paddr);
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign cfg_wr = wr_acc && hit && pstrb[0] && paddr == ACP_OFS_CFG;

  // register file, byte lane 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= ACP_RST_CFG;
      pin_ff <= ACP_RST_PIN_ALL;
    end else if (clk_en && wr_acc && hit && pstrb[0]) begin
      unique case (paddr)
        ACP_OFS_CFG: cfg_ff <= pwdata[7:0];
        ACP_OFS_PIN_LO: pin_ff[7:0] <= pwdata[7:0];
        ACP_OFS_PIN_MID: pin_ff[15:8] <= pwdata[7:0];
        ACP_OFS_PIN_HI: pin_ff[23:16] <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // read data and error answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pslverr_ff <= psel && !penable && !reg_hit(paddr);
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ACP_OFS_CFG: prdata_ff <= {24'h00_0000, cfg_ff};
          ACP_OFS_PIN_LO: prdata_ff <= {24'h00_0000, pin_ff[7:0]};
          ACP_OFS_PIN_MID: prdata_ff <= HAS_MID ? {24'h00_0000, pin_ff[15:8]} : 32'h0000_0000;
          ACP_OFS_PIN_HI: prdata_ff <= HAS_HI ? {24'h00_0000, pin_ff[23:16]} : 32'h0000_0000;
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // conversion abort pulse on configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      abort_ff <= 1'b0;
    else if (clk_en)
      abort_ff <= cfg_wr;
  end

  // field decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lpc_ff <= 1'b0;
      lsmp_ff <= 1'b0;
      mode_ff <= 2'b00;
      m10_ff <= 1'b0;
      mrsv_ff <= 1'b0;
    end else if (clk_en) begin
      lpc_ff <= cfg_ff[ACP_CFG_LPC_BIT];
      lsmp_ff <= cfg_ff[ACP_CFG_LSMP_BIT];
      mode_ff <= cfg_ff[ACP_CFG_MODE_LSB +: 2];
      m10_ff <= acp_mode_t'(cfg_ff[ACP_CFG_MODE_LSB +: 2]) == ACP_MODE_10B;
      mrsv_ff <= cfg_ff[ACP_CFG_MODE_LSB];
    end
  end

  // pin controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dis_ff <= ACP_RST_PIN_ALL;
    else if (clk_en)
      dis_ff <= pin_ff & CH_PRESENT;
  end

  // source clock synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_sync_ff <= 2'b00;
      async_sync_ff <= 2'b00;
      alt_prev_ff <= 1'b0;
      async_prev_ff <= 1'b0;
      half_ff <= 1'b0;
    end else if (clk_en) begin
      alt_sync_ff <= {alt_sync_ff[0], alternate_clock_source};
      async_sync_ff <= {async_sync_ff[0], internal_async_clock};
      alt_prev_ff <= alt_sync_ff[1];
      async_prev_ff <= async_sync_ff[1];
      half_ff <= !half_ff;
    end
  end

  always_comb begin
    unique case (acp_src_t'(cfg_ff[ACP_CFG_CLK_LSB +: 2]))
      ACP_SRC_BUS: src_tick = 1'b1;
      ACP_SRC_BUS_HALF: src_tick = half_ff;
      ACP_SRC_ALT: src_tick = alt_sync_ff[1] && !alt_prev_ff;
      ACP_SRC_ASYNC: src_tick = async_sync_ff[1] && !async_prev_ff;
    endcase
  end

  acp_clk_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .src_tick(src_tick),
    .div_sel(cfg_ff[ACP_CFG_DIV_LSB +: 2]),
    .restart(cfg_wr),
    .tick_ff(div_tick)
  );

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff;
  assign low_power_select = lpc_ff;
  assign long_sample_select = lsmp_ff;
  assign mode_select = mode_ff;
  assign mode_10bit = m10_ff;
  assign mode_reserved = mrsv_ff;
  assign converter_clock = div_tick;
  assign conversion_abort = abort_ff;
  assign pin_out_tristate = dis_ff;
  assign pin_pullup_off = dis_ff;
  assign pin_input_off = dis_ff;

  // assertion helpers
  sequence s_cfg_quiet;
    clk_en && cfg_ff[6:0] == 7'h00 && !cfg_wr;
  endsequence

  sequence s_cfg_write;
    clk_en && cfg_wr;
  endsequence

  sequence s_setup_phase;
    clk_en && psel && !penable;
  endsequence

  a_abort_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> conversion_abort) else $error("abort missing");

  a_abort_cause: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && conversion_abort |-> $past(cfg_wr)) else $error("spurious abort");

  a_abort_single: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_write ##1 (clk_en && !cfg_wr) |=> !conversion_abort)
    else $error("abort too long");

  a_lpc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> low_power_select == $past(cfg_ff[7]))
    else $error("low power wrong");

  a_lsmp_follow: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> long_sample_select == $past(cfg_ff[4]))
    else $error("sample wrong");

  a_mode_dec: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> mode_10bit == ($past(cfg_ff[3:2]) == 2'b10))
    else $error("mode wrong");

  a_mode_copy: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> mode_select == $past(cfg_ff[3:2]))
    else $error("mode field wrong");

  a_reserved_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> mode_reserved == $past(cfg_ff[2]))
    else $error("reserved flag wrong");

  a_pin_low: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) |-> pin_input_off[7:0] == ($past(pin_ff[7:0]) & CH_PRESENT[7:0]))
    else $error("low pins wrong");

  a_pin_mid: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en)
    |-> pin_out_tristate[15:8] == ($past(pin_ff[15:8]) & CH_PRESENT[15:8]))
    else $error("mid pins wrong");

  a_pin_high: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en)
    |-> pin_pullup_off[23:16] == ($past(pin_ff[23:16]) & CH_PRESENT[23:16]))
    else $error("high pins wrong");

  a_pins_agree: assert property (@(posedge pclk) disable iff (!presetn)
    pin_out_tristate == pin_input_off && pin_pullup_off == pin_input_off)
    else $error("pin controls disagree");

  a_absent_ch: assert property (@(posedge pclk) disable iff (!presetn)
    (pin_input_off & ~CH_PRESENT) == 24'h00_0000) else $error("absent pin driven");

  a_bus_clk: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_quiet ##1 s_cfg_quiet |=> converter_clock) else $error("bus clock tick missing");

  a_bus_src: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_ff[1:0] == 2'b00 |-> src_tick) else $error("bus source tick missing");

  a_half_rate: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en) && cfg_ff[1:0] == 2'b01 && $past(cfg_ff[1:0]) == 2'b01
    |-> src_tick != $past(src_tick)) else $error("half rate source wrong");

  a_div_restart: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> !converter_clock) else $error("divider not restarted");

  a_cfg_store: assert property (@(posedge pclk) disable iff (!presetn)
    s_cfg_write |=> cfg_ff == $past(pwdata[7:0])) else $error("config not stored");

  a_write_refused: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && !hit |=> $stable(cfg_ff) && $stable(pin_ff))
    else $error("unmapped write stored");

  a_strb_refused: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && wr_acc && !pstrb[0] |=> $stable(cfg_ff) && $stable(pin_ff))
    else $error("masked write stored");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_phase ##0 !hit |=> pslverr) else $error("error answer missing");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_phase ##0 hit |=> !pslverr) else $error("spurious error answer");

  a_rd_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_phase ##0 (!pwrite && paddr == ACP_OFS_CFG)
    |=> prdata == {24'h00_0000, $past(cfg_ff)}) else $error("config read wrong");

  a_rd_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_phase ##0 (!pwrite && paddr == ACP_OFS_PIN_LO)
    |=> prdata == {24'h00_0000, $past(pin_ff[7:0])}) else $error("low pin read wrong");

  a_rd_absent: assert property (@(posedge pclk) disable iff (!presetn)
    s_setup_phase ##0 (!pwrite && !hit) |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_rd_upper: assert property (@(posedge pclk) disable iff (!presetn)
    prdata[31:8] == 24'h00_0000) else $error("upper read bits set");

  a_frozen_regs: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(cfg_ff) && $stable(pin_ff)) else $error("registers moved when frozen");

  a_frozen_outs: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_en |=> $stable(pin_input_off) && $stable(conversion_abort) && $stable(converter_clock))
    else $error("outputs moved when frozen");
endmodule // acp_top

// [bench/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acp_pkg::*;
  logic pclk = 0;
  logic presetn = 0;
  logic clk_en = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic alternate_clock_source = 0;
  logic internal_async_clock = 0;
  logic low_power_select, long_sample_select, mode_10bit, mode_reserved;
  logic converter_clock, conversion_abort;
  logic [1:0] mode_select;
  logic [23:0] pin_out_tristate, pin_pullup_off, pin_input_off;
  logic [31:0] rd;
  logic err;
  logic [1:0] m;
  int miscompares = 0;
  int n_tests = 0;
  int c;
  int per[4] = '{1, 2, 8, 16};
  // channel 15 and the whole high byte absent
  localparam logic [23:0] PRESENT = 24'h00_7FFF;

  acp_top #(.CH_PRESENT(PRESENT)) u_acp_top (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .alternate_clock_source,
    .internal_async_clock, .low_power_select, .long_sample_select, .mode_select, .mode_10bit,
    .mode_reserved, .converter_clock, .conversion_abort, .pin_out_tristate, .pin_pullup_off,
    .pin_input_off);

  initial forever #4 pclk = ~pclk;
  always begin
    repeat (4) @(posedge pclk);
    alternate_clock_source <= ~alternate_clock_source;
  end
  always begin
    repeat (8) @(posedge pclk);
    internal_async_clock <= ~internal_async_clock;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    xfer(0, a, 32'h0000_0000, 4'h0);
    chk("read data", rd, exp);
    chk("slave error", {31'h0, err}, {31'h0, eerr});
  endtask

  // write, then count abort pulses over the following cycles
  task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input int n_abort);
    xfer(1, a, d, s);
    c = 0;
    repeat (3) begin
      @(negedge pclk);
      if (conversion_abort === 1'b1) c++;
    end
    chk("abort pulses", c, n_abort);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rchk(ACP_OFS_CFG, 32'h0000_0000, 0);
    rchk(ACP_OFS_PIN_LO, 32'h0000_0000, 0);
    rchk(ACP_OFS_PIN_MID, 32'h0000_0000, 0);
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      wchk(ACP_OFS_CFG, {24'h0, m[1], 2'b00, m[0], m, 2'b00}, 4'h1, 1);
      chk("low power", low_power_select, m[1]);
      chk("long sample", long_sample_select, m[0]);
      chk("mode", mode_select, m);
      chk("ten bit", mode_10bit, m == 2'b10);
      chk("reserved", mode_reserved, m[0]);
      rchk(ACP_OFS_CFG, {24'h0, m[1], 2'b00, m[0], m, 2'b00}, 0);
    end
    wchk(ACP_OFS_PIN_LO, 32'h0000_00A5, 4'h1, 0);
    wchk(ACP_OFS_PIN_MID, 32'h0000_00FF, 4'h1, 0);
    wchk(ACP_OFS_PIN_HI, 32'h0000_00FF, 4'h1, 0);
    chk("hi write error", err, 1);
    chk("tristate", pin_out_tristate, 24'h00_7FA5);
    chk("pullup off", pin_pullup_off, 24'h00_7FA5);
    chk("input off", pin_input_off, 24'h00_7FA5);
    rchk(ACP_OFS_PIN_MID, 32'h0000_00FF, 0);
    rchk(ACP_OFS_PIN_HI, 32'h0000_0000, 1);
    rchk(12'h010, 32'h0000_0000, 1);
    wchk(ACP_OFS_PIN_LO, 32'h0000_005A, 4'h0, 0);
    @(posedge pclk);
    clk_en <= 0;
    wchk(ACP_OFS_PIN_LO, 32'h0000_0011, 4'h1, 0);
    @(posedge pclk);
    clk_en <= 1;
    rchk(ACP_OFS_PIN_LO, 32'h0000_00A5, 0);
    wchk(ACP_OFS_PIN_LO, 32'h0000_0000, 4'h1, 0);
    chk("tristate clear", pin_out_tristate, 24'h00_7F00);
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wchk(ACP_OFS_CFG, {25'h0, d[1:0], 3'b000, s[1:0]}, 4'h1, 1);
        repeat (40) @(posedge pclk);
        c = 0;
        repeat (128) begin
          @(negedge pclk);
          if (converter_clock === 1'b1) c++;
        end
        chk("ticks", c, 128 / (per[s] << d));
      end
    end
    @(posedge pclk);
    presetn <= 0;
    @(negedge pclk);
    chk("reset tristate", pin_out_tristate, 24'h00_0000);
    chk("reset mode", mode_select, 2'b00);
    @(posedge pclk);
    presetn <= 1;
    rchk(ACP_OFS_CFG, 32'h0000_0000, 0);
    rchk(ACP_OFS_PIN_MID, 32'h0000_0000, 0);
    final_report();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    final_report();
  end
endmodule // testbench
